// ---- design/scc_clock_ctrl.sv ----
// Purpose: System clock control registers: oscillator, warm-up, gear, prescaler
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes: Stop-mode input is asynchronous and is synchronised
`timescale 1ns/1ps
module scc_clock_ctrl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Register port
  input wire logic [31:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Stop mode pin
  input wire logic stop_mode_i,
  // Clock controls
  output logic hs_osc_run_o,
  output logic sysclk_low_o,
  output logic ls_gear_div2_o,
  output logic periph_src_hs_o,
  output logic [1:0] presc_sel_o,
  output logic [3:0] gear_num_o,
  output logic gear_tick_o,
  output logic presc_tick_o,
  // Interrupt
  output logic irq_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic osc_en;
    logic keep1_hi;
    logic after_stop;
    logic keep1_lo;
    logic [1:0] presc;
    logic src_sel;
    logic periph_src;
    logic ls_div2;
    logic [2:0] gear;
    scc_pkg::scc_clk_state_t cst;
    logic flag;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [7:0] rdata;
    logic irq;
    logic osc_run;
    logic [3:0] gear_num;
    logic [3:0] pcnt;
    logic ptick;
    logic stop_s1;
    logic stop_s2;
    logic stop_d;
  } scc_state_t;

  scc_state_t r;
  scc_state_t n;

  logic wu_busy;
  logic wu_done;
  logic gear_tick;
  logic wr_osc;
  logic wr_gear;
  logic wr_mask;
  logic rd_osc;
  logic rd_gear;
  logic rd_stat;
  logic rd_mask;
  logic warm_start;
  logic stop_rel;
  logic sw_evt;
  logic base_tick;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  assign wr_osc = wr_i && (addr_i == scc_pkg::SCC_OSC_CTRL_ADDR);
  assign wr_gear = wr_i && (addr_i == scc_pkg::SCC_GEAR_CTRL_ADDR);
  assign wr_mask = wr_i && (addr_i == scc_pkg::SCC_IRQ_MASK_ADDR);
  assign rd_osc = rd_i && (addr_i == scc_pkg::SCC_OSC_CTRL_ADDR);
  assign rd_gear = rd_i && (addr_i == scc_pkg::SCC_GEAR_CTRL_ADDR);
  assign rd_stat = rd_i && (addr_i == scc_pkg::SCC_IRQ_STAT_ADDR);
  assign rd_mask = rd_i && (addr_i == scc_pkg::SCC_IRQ_MASK_ADDR);

  assign warm_start = wr_osc && wdata_i[scc_pkg::SCC_WARMUP_BIT];
  assign stop_rel = r.stop_d && !r.stop_s2;

  // ----------------------------------------
  // Warm-up timer and gear
  // ----------------------------------------
  scc_warmup i_scc_warmup (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .start_i(warm_start),
    .busy_o(wu_busy),
    .done_o(wu_done)
  );

  scc_gear i_scc_gear (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .num_i(r.gear_num),
    .tick_o(gear_tick)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = r;
    sw_evt = 1'b0;
    n.stop_s1 = stop_mode_i;
    n.stop_s2 = r.stop_s1;
    n.stop_d = r.stop_s2;

    if (wr_osc) begin
      n.osc_en = wdata_i[scc_pkg::SCC_OSC_EN_BIT];
      n.keep1_hi = wdata_i[scc_pkg::SCC_KEEP1_HI_BIT];
      n.after_stop = wdata_i[scc_pkg::SCC_AFTER_STOP_BIT];
      n.keep1_lo = wdata_i[scc_pkg::SCC_KEEP1_LO_BIT];
      n.presc = wdata_i[scc_pkg::SCC_PRESC_LSB +: 2];
    end
    // Release outranks a same-cycle write so the wake-up choice holds
    if (stop_rel) begin
      n.osc_en = r.after_stop;
    end

    if (wr_gear) begin
      n.src_sel = wdata_i[scc_pkg::SCC_SRC_SEL_BIT];
      n.periph_src = wdata_i[scc_pkg::SCC_PERIPH_SRC_BIT];
      n.ls_div2 = wdata_i[scc_pkg::SCC_LS_GEAR_BIT];
      // Reserved code is dropped, the old gear stays
      if (wdata_i[scc_pkg::SCC_HS_GEAR_LSB +: 3] != scc_pkg::SCC_GEAR_RSVD) begin
        n.gear = wdata_i[scc_pkg::SCC_HS_GEAR_LSB +: 3];
      end
    end
    n.gear_num = scc_pkg::scc_gear_num(n.gear);

    // Oscillator is held off throughout stop mode
    n.osc_run = n.osc_en && !r.stop_s2;

    // Source switch: back to high speed waits for a warm oscillator
    unique case (r.cst)
      scc_pkg::SCC_RUN_HS: begin
        if (n.src_sel) begin
          n.cst = scc_pkg::SCC_RUN_LS;
          sw_evt = 1'b1;
        end
      end
      scc_pkg::SCC_RUN_LS: begin
        if (!n.src_sel) begin
          n.cst = scc_pkg::SCC_TO_HS;
        end
      end
      scc_pkg::SCC_TO_HS: begin
        if (n.src_sel) begin
          n.cst = scc_pkg::SCC_RUN_LS;
        end else if (r.osc_run && !wu_busy) begin
          n.cst = scc_pkg::SCC_RUN_HS;
          sw_evt = 1'b1;
        end
      end
      default: begin
        n.cst = scc_pkg::SCC_RUN_HS;
      end
    endcase
    n.flag = (n.cst != scc_pkg::SCC_RUN_HS);

    // Peripheral base clock, then prescaler divide
    base_tick = r.periph_src ? 1'b1 : gear_tick;
    n.ptick = 1'b0;
    if (base_tick) begin
      if (r.pcnt >= scc_pkg::scc_presc_last(r.presc)) begin
        n.pcnt = 4'h0;
        n.ptick = 1'b1;
      end else begin
        n.pcnt = r.pcnt + 4'h1;
      end
    end

    // Sticky events; a new event beats the read that clears it
    if (rd_stat) begin
      n.stat = 2'h0;
    end
    if (wu_done) begin
      n.stat[scc_pkg::SCC_IRQ_WARMUP_BIT] = 1'b1;
    end
    if (sw_evt) begin
      n.stat[scc_pkg::SCC_IRQ_SWITCH_BIT] = 1'b1;
    end
    if (wr_mask) begin
      n.mask = wdata_i[1:0];
    end
    n.irq = |(n.stat & n.mask);

    // Read data stands for one cycle; unmapped reads give zero
    n.rdata = 8'h00;
    if (rd_osc) begin
      n.rdata = {r.osc_en, r.keep1_hi, r.after_stop, r.keep1_lo, 1'b0,
                 wu_busy, r.presc};
    end else if (rd_gear) begin
      n.rdata = {1'b0, r.flag, r.src_sel, r.periph_src, r.ls_div2, r.gear};
    end else if (rd_stat) begin
      n.rdata = {6'h00, r.stat};
    end else if (rd_mask) begin
      n.rdata = {6'h00, r.mask};
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      r <= '0;
      {r.osc_en, r.keep1_hi, r.after_stop, r.keep1_lo} <= scc_pkg::SCC_OSC_CTRL_RST[7:4];
      r.presc <= scc_pkg::SCC_OSC_CTRL_RST[1:0];
      r.src_sel <= scc_pkg::SCC_GEAR_CTRL_RST[5];
      r.periph_src <= scc_pkg::SCC_GEAR_CTRL_RST[4];
      r.ls_div2 <= scc_pkg::SCC_GEAR_CTRL_RST[3];
      r.gear <= scc_pkg::SCC_GEAR_CTRL_RST[2:0];
      r.gear_num <= scc_pkg::scc_gear_num(scc_pkg::SCC_GEAR_CTRL_RST[2:0]);
      r.cst <= scc_pkg::SCC_RUN_HS;
      r.mask <= scc_pkg::SCC_IRQ_MASK_RST;
      r.osc_run <= 1'b1;
    end else if (ce_i) begin
      r <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata_o = r.rdata;
  assign hs_osc_run_o = r.osc_run;
  assign sysclk_low_o = r.flag;
  assign ls_gear_div2_o = r.ls_div2;
  assign periph_src_hs_o = r.periph_src;
  assign presc_sel_o = r.presc;
  assign gear_num_o = r.gear_num;
  assign gear_tick_o = gear_tick;
  assign presc_tick_o = r.ptick;
  assign irq_o = r.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i || !ce_i);

  sequence s_warm_start;
    wr_osc && wdata_i[scc_pkg::SCC_WARMUP_BIT];
  endsequence

  sequence s_back_to_hs;
    r.cst == scc_pkg::SCC_TO_HS && wu_busy;
  endsequence

  osc_stop_a: assert property (wr_osc && !wdata_i[7] && !stop_rel
    |=> !hs_osc_run_o)
    else $error("Oscillator still runs after disable");

  stop_wake_a: assert property (stop_rel |=> r.osc_en == $past(r.after_stop))
    else $error("Stop release ignored after-stop bit");

  rsvd_zero_a: assert property ((rd_osc |=> !rdata_o[3]) and (rd_gear |=> !rdata_o[7]))
    else $error("Reserved bit read nonzero");

  warm_start_a: assert property (s_warm_start |=> wu_busy ##0 rdata_o == 8'h00)
    else $error("Warm-up start failed");

  warm_read_a: assert property (rd_osc |=> rdata_o[2] == $past(wu_busy))
    else $error("Warm-up bit reads wrong");

  presc_div_a: assert property (r.ptick |->
    $past(r.pcnt) >= scc_pkg::scc_presc_last($past(r.presc)))
    else $error("Prescaler ticked early");

  hs_hold_a: assert property (s_back_to_hs |=> sysclk_low_o)
    else $error("Flag left low speed before warm-up end");

  sel_low_a: assert property (wr_gear && wdata_i[5] |=> sysclk_low_o[*2])
    else $error("Low-speed select not reflected");

  gear_rsvd_a: assert property (wr_gear && wdata_i[2:0] == 3'h5 |=> $stable(r.gear))
    else $error("Reserved gear code accepted");

  gear_slow_a: assert property (wr_gear && wdata_i[2:0] == 3'h7 |=> gear_num_o == 4'h1)
    else $error("Gear 111 not one eighth");

  reset_val_a: assert property ($past(!rst_b_i) |-> r.osc_en && r.gear == 3'h7)
    else $error("Reset values wrong");

endmodule : scc_clock_ctrl

// ---- design/scc_gear.sv ----
// Purpose: Fractional gear tick generator for the high-speed clock
// Assumes: num_i in 1..8 eighths
// Notes: Ticks are spread evenly by a phase accumulator
`timescale 1ns/1ps
module scc_gear (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Ratio
  input wire logic [3:0] num_i,
  // Tick
  output logic tick_o
);

  typedef struct packed {
    logic [3:0] acc;
    logic tick;
  } scc_gr_state_t;

  scc_gr_state_t r;
  scc_gr_state_t n;
  logic [4:0] sum;

  always_comb begin
    n = r;
    sum = {1'b0, r.acc} + {1'b0, num_i};
    if (sum >= 5'h08) begin
      n.acc = 4'(sum - 5'h08);
      n.tick = 1'b1;
    end else begin
      n.acc = sum[3:0];
      n.tick = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= n;
    end
  end

  assign tick_o = r.tick;

  gear_full_a: assert property (@(posedge clk_i) disable iff (!rst_b_i || !ce_i)
    (num_i == 4'h8) |=> tick_o)
    else $error("Undivided gear missed a tick");

endmodule : scc_gear

// ---- design/scc_pkg.sv ----
// Purpose: Shared constants and helpers for the system clock control registers
// Assumes: 40 MHz system clock, byte-wide registers
// Notes: Prescaler and gear outputs are clock-enable ticks, not clocks
package scc_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [31:0] SCC_OSC_CTRL_ADDR = 32'hffffee00;
  localparam logic [31:0] SCC_GEAR_CTRL_ADDR = 32'hffffee01;
  localparam logic [31:0] SCC_IRQ_STAT_ADDR = 32'hffffee10;
  localparam logic [31:0] SCC_IRQ_MASK_ADDR = 32'hffffee11;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] SCC_OSC_CTRL_RST = 8'hf0;
  localparam logic [7:0] SCC_GEAR_CTRL_RST = 8'h07;
  localparam logic [1:0] SCC_IRQ_MASK_RST = 2'h0;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SCC_OSC_EN_BIT = 7;
  localparam int SCC_KEEP1_HI_BIT = 6;
  localparam int SCC_AFTER_STOP_BIT = 5;
  localparam int SCC_KEEP1_LO_BIT = 4;
  localparam int SCC_WARMUP_BIT = 2;
  localparam int SCC_PRESC_LSB = 0;
  localparam int SCC_SRC_FLAG_BIT = 6;
  localparam int SCC_SRC_SEL_BIT = 5;
  localparam int SCC_PERIPH_SRC_BIT = 4;
  localparam int SCC_LS_GEAR_BIT = 3;
  localparam int SCC_HS_GEAR_LSB = 0;
  localparam int SCC_IRQ_WARMUP_BIT = 0;
  localparam int SCC_IRQ_SWITCH_BIT = 1;
  localparam logic [2:0] SCC_GEAR_RSVD = 3'h5;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SCC_CLK_MHZ = 40;
  localparam int SCC_WARMUP_NS = 100000;
  localparam int SCC_WARMUP_CYCLES = (SCC_WARMUP_NS * SCC_CLK_MHZ + 999) / 1000;

  // ----------------------------------------
  // Types and helpers
  // ----------------------------------------
  typedef enum logic [1:0] {SCC_RUN_HS, SCC_RUN_LS, SCC_TO_HS} scc_clk_state_t;

  // Eighths of the high-speed clock passed by each gear code
  function automatic logic [3:0] scc_gear_num(input logic [2:0] code);
    unique case (code)
      3'h0: scc_gear_num = 4'h8;
      3'h1: scc_gear_num = 4'h7;
      3'h2: scc_gear_num = 4'h6;
      3'h3: scc_gear_num = 4'h5;
      3'h4: scc_gear_num = 4'h4;
      3'h6: scc_gear_num = 4'h2;
      3'h7: scc_gear_num = 4'h1;
      default: scc_gear_num = 4'h8;
    endcase
  endfunction : scc_gear_num

  // Prescaler divide ratio minus one, per select code
  function automatic logic [3:0] scc_presc_last(input logic [1:0] code);
    unique case (code)
      2'h0: scc_presc_last = 4'hf;
      2'h1: scc_presc_last = 4'h7;
      2'h2: scc_presc_last = 4'h3;
      2'h3: scc_presc_last = 4'h1;
    endcase
  endfunction : scc_presc_last

endpackage : scc_pkg

// ---- design/scc_warmup.sv ----
// Purpose: Oscillator warm-up timer
// Assumes: start_i is a one-cycle pulse on clk_i
// Notes: A start while busy restarts the full count
`timescale 1ns/1ps
module scc_warmup (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // Control
  input wire logic start_i,
  // Status
  output logic busy_o,
  output logic done_o
);

  typedef struct packed {
    logic [11:0] cnt;
    logic busy;
    logic done;
  } scc_wu_state_t;

  scc_wu_state_t r;
  scc_wu_state_t n;

  always_comb begin
    n = r;
    n.done = 1'b0;
    if (start_i) begin
      n.cnt = 12'(scc_pkg::SCC_WARMUP_CYCLES - 1);
      n.busy = 1'b1;
    end else if (r.busy) begin
      if (r.cnt == 12'h000) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end else begin
        n.cnt = r.cnt - 12'h001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= n;
    end
  end

  assign busy_o = r.busy;
  assign done_o = r.done;

endmodule : scc_warmup

// ---- verif/system_clock_control_regs_test.sv ----
// Purpose: Self-checking bench for the system clock control registers
// Assumes: Register port with read data in the cycle after the read strobe
// Notes: Warm-up runs its full 4000 cycles, so that scenario dominates run time
`timescale 1ns/1ps
module system_clock_control_regs_test;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic [31:0] addr_i = 32'h0;
  logic [7:0] wdata_i = 8'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic stop_mode_i = 1'b0;
  logic [7:0] rdata_o;
  logic hs_osc_run_o;
  logic sysclk_low_o;
  logic ls_gear_div2_o;
  logic periph_src_hs_o;
  logic [1:0] presc_sel_o;
  logic [3:0] gear_num_o;
  logic gear_tick_o;
  logic presc_tick_o;
  logic irq_o;
  logic [7:0] d;
  int fail_count = 0;
  int n_compared = 0;

  scc_clock_ctrl i_scc_clock_ctrl (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .stop_mode_i(stop_mode_i),
    .hs_osc_run_o(hs_osc_run_o), .sysclk_low_o(sysclk_low_o),
    .ls_gear_div2_o(ls_gear_div2_o), .periph_src_hs_o(periph_src_hs_o),
    .presc_sel_o(presc_sel_o), .gear_num_o(gear_num_o), .gear_tick_o(gear_tick_o),
    .presc_tick_o(presc_tick_o), .irq_o(irq_o)
  );

  always #12.5 clk_i = ~clk_i;

  // ----------------------------------------
  // Bus and compare helpers
  // ----------------------------------------
  task print_verdict;
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  task chkb(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chkb

  task cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  task wr(input logic [31:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr

  task rdchk(input logic [31:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
    chk(d, exp);
  endtask : rdchk

  // Cycles from one prescaler tick to the next; a missing tick ends the run
  task per(output int n);
    int k;
    k = 0;
    while (presc_tick_o !== 1'b1 && k < 100) begin
      cyc(1);
      k++;
    end
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (presc_tick_o !== 1'b1 && n < 100);
    if (k >= 100 || n >= 100) begin
      fail_count++;
      $display("ERROR %0t prescaler tick missing", $time);
      print_verdict();
    end
  endtask : per

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    rdchk(scc_pkg::SCC_OSC_CTRL_ADDR, 8'hf0);
    rdchk(scc_pkg::SCC_GEAR_CTRL_ADDR, 8'h07);
    rdchk(scc_pkg::SCC_IRQ_MASK_ADDR, 8'h00);
    rdchk(32'hffffee20, 8'h00);
    chkb(hs_osc_run_o, 1'b1);
    chkb(sysclk_low_o, 1'b0);
    chk({4'h0, gear_num_o}, 8'h01);
    // Frozen clock enable: a write must leave no trace
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(scc_pkg::SCC_GEAR_CTRL_ADDR, 8'h10);
    chk({4'h0, gear_num_o}, 8'h01);
    chkb(periph_src_hs_o, 1'b0);
    @(posedge clk_i);
    ce_i <= 1'b1;
    rdchk(scc_pkg::SCC_GEAR_CTRL_ADDR, 8'h07);
  endtask : t_reset

  task t_rerst;
    wr(scc_pkg::SCC_GEAR_CTRL_ADDR, 8'h10);
    wr(scc_pkg::SCC_OSC_CTRL_ADDR, 8'h53);
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    rdchk(scc_pkg::SCC_OSC_CTRL_ADDR, 8'hf0);
    rdchk(scc_pkg::SCC_GEAR_CTRL_ADDR, 8'h07);
    chk({4'h0, gear_num_o}, 8'h01);
    chkb(hs_osc_run_o, 1'b1);
  endtask : t_rerst

  task t_gear;
    logic [3:0] eighth [8];
    int n;
    eighth = '{4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h0, 4'h2, 4'h1};
    for (int c = 0; c < 8; c++) begin
      if (c != 5) begin
        wr(scc_pkg::SCC_GEAR_CTRL_ADDR, 8'h80 | c[7:0]);
        rdchk(scc_pkg::SCC_GEAR_CTRL_ADDR, c[7:0]);
        chk({4'h0, gear_num_o}, {4'h0, eighth[c]});
        n = 0;
        repeat (64) begin
          cyc(1);
          if (gear_tick_o === 1'b1) n++;
        end
        chk(n[7:0], {1'b0, eighth[c], 3'h0});
      end
    end
    wr(scc_pkg::SCC_GEAR_CTRL_ADDR, 8'h05);
    rdchk(scc_pkg::SCC_GEAR_CTRL_ADDR, 8'h07);
  endtask : t_gear

  task t_presc;
    int n;
    wr(scc_pkg::SCC_GEAR_CTRL_ADDR, 8'h1f);
    chkb(ls_gear_div2_o, 1'b1);
    chkb(periph_src_hs_o, 1'b1);
    for (int c = 0; c < 4; c++) begin
      wr(scc_pkg::SCC_OSC_CTRL_ADDR, 8'hf0 | c[7:0]);
      chk({6'h0, presc_sel_o}, c[7:0]);
      per(n);
      per(n);
      chk(n[7:0], 8'h10 >> c);
    end
    // Base is now the 1/8 gear tick, so the /2 prescaler ticks every 16 cycles
    wr(scc_pkg::SCC_GEAR_CTRL_ADDR, 8'h07);
    chkb(ls_gear_div2_o, 1'b0);
    per(n);
    per(n);
    chk(n[7:0], 8'h10);
    wr(scc_pkg::SCC_OSC_CTRL_ADDR, 8'hf0);
  endtask : t_presc

  task t_warm;
    rdchk(scc_pkg::SCC_IRQ_STAT_ADDR, 8'h00);
    wr(scc_pkg::SCC_IRQ_MASK_ADDR, 8'h01);
    wr(scc_pkg::SCC_GEAR_CTRL_ADDR, 8'h27);
    wr(scc_pkg::SCC_OSC_CTRL_ADDR, 8'hf4);
    // High speed asked for while warming: the switch must wait for the timer
    wr(scc_pkg::SCC_GEAR_CTRL_ADDR, 8'h07);
    rdchk(scc_pkg::SCC_OSC_CTRL_ADDR, 8'hf4);
    wr(scc_pkg::SCC_OSC_CTRL_ADDR, 8'hf0);
    cyc(3980);
    rdchk(scc_pkg::SCC_OSC_CTRL_ADDR, 8'hf4);
    chkb(irq_o, 1'b0);
    chkb(sysclk_low_o, 1'b1);
    cyc(20);
    rdchk(scc_pkg::SCC_OSC_CTRL_ADDR, 8'hf0);
    chkb(irq_o, 1'b1);
    chkb(sysclk_low_o, 1'b0);
    rdchk(scc_pkg::SCC_IRQ_STAT_ADDR, 8'h03);
    chkb(irq_o, 1'b0);
  endtask : t_warm

  task t_switch;
    wr(scc_pkg::SCC_IRQ_MASK_ADDR, 8'h02);
    wr(scc_pkg::SCC_GEAR_CTRL_ADDR, 8'h27);
    chkb(sysclk_low_o, 1'b1);
    rdchk(scc_pkg::SCC_GEAR_CTRL_ADDR, 8'h67);
    chkb(irq_o, 1'b1);
    rdchk(scc_pkg::SCC_IRQ_STAT_ADDR, 8'h02);
    wr(scc_pkg::SCC_GEAR_CTRL_ADDR, 8'h07);
    cyc(4);
    chkb(sysclk_low_o, 1'b0);
    rdchk(scc_pkg::SCC_GEAR_CTRL_ADDR, 8'h07);
    rdchk(scc_pkg::SCC_IRQ_STAT_ADDR, 8'h02);
    wr(scc_pkg::SCC_IRQ_MASK_ADDR, 8'h00);
  endtask : t_switch

  task t_stop;
    wr(scc_pkg::SCC_OSC_CTRL_ADDR, 8'h50);
    chkb(hs_osc_run_o, 1'b0);
    for (int b = 0; b < 2; b++) begin
      wr(scc_pkg::SCC_OSC_CTRL_ADDR, b[0] ? 8'hf0 : 8'hd0);
      chkb(hs_osc_run_o, 1'b1);
      @(posedge clk_i);
      stop_mode_i <= 1'b1;
      cyc(5);
      chkb(hs_osc_run_o, 1'b0);
      @(posedge clk_i);
      stop_mode_i <= 1'b0;
      cyc(5);
      chkb(hs_osc_run_o, b[0]);
      rdchk(scc_pkg::SCC_OSC_CTRL_ADDR, b[0] ? 8'hf0 : 8'h50);
    end
  endtask : t_stop

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_gear();
    t_presc();
    t_warm();
    t_switch();
    t_stop();
    t_rerst();
    print_verdict();
  end
endmodule : system_clock_control_regs_test
